// ==== design/rgm_pkg.sv ====
// Shared constants and types for both ends of the reduced gigabit link.
// Assumes one 100 MHz system clock at each end.
package rgm_pkg;
  localparam int SYS_HZ = 100_000_000;
  // Nominal link clock rates per speed grade
  localparam int RATE_1000_HZ = 125_000_000;
  localparam int RATE_100_HZ = 25_000_000;
  localparam int RATE_10_HZ = 2_500_000;
  // Half link period in system cycles: rounded down, never below one
  localparam int HALF_1000 = (SYS_HZ / (2 * RATE_1000_HZ) < 1) ? 1 :
    SYS_HZ / (2 * RATE_1000_HZ);
  localparam int HALF_100 = (SYS_HZ / (2 * RATE_100_HZ) < 1) ? 1 :
    SYS_HZ / (2 * RATE_100_HZ);
  localparam int HALF_10 = (SYS_HZ / (2 * RATE_10_HZ) < 1) ? 1 :
    SYS_HZ / (2 * RATE_10_HZ);
  localparam int CNT_W = 8;
  // Speed field codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // In-band status nibble layout
  localparam int ST_LINK_BIT = 0;
  localparam int ST_SPD_LSB = 1;
  localparam int ST_DPX_BIT = 3;
  // Control codes carried with enable low and error high
  localparam logic [7:0] CODE_LPI = 8'h01;
  localparam logic [7:0] CODE_FALSE_CAR = 8'h0E;
  localparam logic [7:0] CODE_EXT = 8'h0F;
  localparam logic [7:0] CODE_EXT_ERR = 8'h1F;
  localparam logic [7:0] CODE_CAR_SENSE = 8'hFF;
  // Interface mode select
  localparam logic [1:0] MODE_RGMII = 2'h0;
  localparam logic [1:0] MODE_SERIAL = 2'h1;
  localparam logic [1:0] MODE_RTBI = 2'h2;
  localparam logic [1:0] MODE_OTHER = 2'h3;
  // Clock skew taps in system cycles
  localparam int SKEW_W = 3;
  localparam logic [2:0] SKEW_RST = 3'h0;
  localparam logic [2:0] SKEW_DEF_ID = 3'h0;
  // Buffer entry: {valid/enable, error, byte}
  localparam int ENTRY_W = 10;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [2:0] {
    K_IDLE, K_LPI, K_EXT, K_EXT_ERR, K_DATA, K_ERR_PROP, K_RSVD
  } rgm_kind_t;
endpackage : rgm_pkg

// ==== design/rgm_if.sv ====
// Pin bundle between the MAC end and the device end.
// Each direction carries a source clock, a control line and a nibble.
`timescale 1ns/1ps
interface rgm_if;
  logic txc;
  logic tx_ctl;
  logic [3:0] txd;
  logic rxc;
  logic rx_ctl;
  logic [3:0] rxd;
  modport phy (input txc, input tx_ctl, input txd, output rxc, output rx_ctl, output rxd);
  modport mac (output txc, output tx_ctl, output txd, input rxc, input rx_ctl, input rxd);
endinterface : rgm_if

// ==== design/rgm_phy.sv ====
// Device end of the link: receive buffer plus link logic.
// Assumes the MAC end drives the transmit clock and keeps its coding.
`timescale 1ns/1ps
module rgm_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  // Extra pointer bit tells full from empty; DEPTH must be a power of two
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push = in_valid & ~full;
  wire pop = out_ready & ~empty;
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem_r[rp_r[AW-1:0]];
  // Storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
  // Pointers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end
endmodule : rgm_fifo

module rgm_phy
  import rgm_pkg::*;
#(
  parameter int HALF_G = HALF_1000,
  parameter int HALF_F = HALF_100,
  parameter int HALF_S = HALF_10,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  rgm_if.phy lnk,
  input wire logic [1:0] if_mode,
  input wire logic link_up,
  input wire logic [1:0] speed,
  input wire logic full_duplex,
  input wire logic loop_en,
  input wire logic ctl_speed_lsb,
  input wire logic ctl_speed_msb,
  input wire logic skew_wr,
  input wire logic [2:0] skew_in_val,
  input wire logic [2:0] skew_out_val,
  input wire logic rxclk_off,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic rx_in_dv,
  input wire logic rx_in_err,
  input wire logic [7:0] rx_in_data,
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  output rgm_kind_t tx_out_kind,
  output logic capability_negotiation_gig_only,
  output logic pcs_en
);
  logic [5:0] ls1_r;
  logic [5:0] ls2_r;
  logic [6:0] sh_in_r;
  logic tck_d_r;
  logic [2:0] skew_in_r;
  logic [2:0] skew_out_r;
  logic init_r;
  logic tctl_r;
  logic [3:0] tnib_r;
  logic [3:0] tlo_r;
  logic tph_r;
  logic [CNT_W-1:0] cnt_r;
  logic clk_r;
  logic [6:0] sh_out_r;
  logic [ENTRY_W-1:0] cur_r;
  logic rph_r;
  logic rctl_r;
  logic [3:0] rnib_r;
  rgm_kind_t kind_w;

  // Mode-dependent boundary outputs
  // gigabit-only negotiation
  assign capability_negotiation_gig_only = (if_mode == MODE_RTBI);
  assign pcs_en = (if_mode == MODE_RTBI);

  // Speed in use; a live link wins over the control bits
  // loop speed selection
  wire [1:0] ctl_spd = {ctl_speed_msb, ctl_speed_lsb};
  wire [1:0] eff_spd = (if_mode == MODE_RTBI) ? SPD_1000 : (link_up ? speed : ctl_spd);
  // Reserved speed code runs the gigabit pattern, as at the MAC end
  wire gig = (eff_spd == SPD_1000) | (eff_spd == 2'h3);
  wire [CNT_W-1:0] half = (eff_spd == SPD_10) ? CNT_W'(HALF_S) :
    (eff_spd == SPD_100) ? CNT_W'(HALF_F) : CNT_W'(HALF_G);

  // Skew taps: loaded by mode once after reset, then by management
  wire id_mode = (if_mode == MODE_RGMII) | (if_mode == MODE_RTBI);
  wire [2:0] skew_def = id_mode ? SKEW_DEF_ID : SKEW_RST;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      skew_in_r <= SKEW_RST;
      skew_out_r <= SKEW_RST;
      init_r <= 1'b0;
    end else if (skew_wr) begin
      skew_in_r <= skew_in_val;
      skew_out_r <= skew_out_val;
      init_r <= 1'b1;
    end else if (!init_r) begin
      skew_in_r <= skew_def;
      skew_out_r <= skew_def;
      init_r <= 1'b1;
    end
  end

  // ingress clock delay; must stay below the half period
  wire [7:0] in_taps = {sh_in_r, ls2_r[5]};
  wire tck = in_taps[skew_in_r];

  // Link pins are foreign to sys_clk: two flops before use
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls1_r <= '0;
      ls2_r <= '0;
      sh_in_r <= '0;
      tck_d_r <= 1'b0;
    end else begin
      ls1_r <= {lnk.txc, lnk.tx_ctl, lnk.txd};
      ls2_r <= ls1_r;
      sh_in_r <= {sh_in_r[5:0], ls2_r[5]};
      tck_d_r <= tck;
    end
  end

  // transmit clock is taken from the MAC
  wire rise_in = tck & ~tck_d_r;
  wire fall_in = ~tck & tck_d_r;
  wire t_ctl = ls2_r[4];
  wire [3:0] t_nib = ls2_r[3:0];
  // second half carries enable xor error
  wire t_er = tctl_r ^ t_ctl;
  wire t_act = tctl_r | t_er;
  // slow speeds take one nibble per period, falling copy ignored
  wire t_done = fall_in & t_act & (gig | tph_r);
  wire [7:0] t_byte = gig ? {t_nib, tnib_r} : {tnib_r, tlo_r};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tctl_r <= 1'b0;
      tnib_r <= 4'h0;
      tlo_r <= 4'h0;
      tph_r <= 1'b0;
    end else if (rise_in) begin
      tctl_r <= t_ctl;
      tnib_r <= t_nib;
    end else if (fall_in) begin
      tlo_r <= tph_r ? tlo_r : tnib_r;
      tph_r <= (t_act && !gig) ? ~tph_r : 1'b0;
    end
  end

  always_comb begin
    kind_w = K_RSVD;
    if (!tctl_r && !t_er) begin
      kind_w = K_IDLE;
    end else if (tctl_r) begin
      kind_w = t_er ? K_ERR_PROP : K_DATA;
    end else if (t_byte == CODE_LPI) begin
      kind_w = K_LPI;
    end else if (t_byte == CODE_EXT) begin
      kind_w = K_EXT;
    end else if (t_byte == CODE_EXT_ERR) begin
      kind_w = K_EXT_ERR;
    end
  end

  // Decoded transmit bytes, registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_valid <= 1'b0;
      tx_out_data <= 8'h00;
      tx_out_kind <= K_IDLE;
    end else begin
      tx_out_valid <= t_done;
      if (t_done) begin
        tx_out_data <= t_byte;
        tx_out_kind <= kind_w;
      end
    end
  end

  // Receive buffer; in loop the decoded transmit stream feeds it and
  // is dropped when full, since the MAC cannot be stalled
  logic f_ready;
  logic f_ovalid;
  logic [ENTRY_W-1:0] f_odata;
  wire f_ivalid = loop_en ? t_done : rx_in_valid;
  wire [ENTRY_W-1:0] f_idata = loop_en ? {tctl_r, t_er, t_byte} :
    {rx_in_dv, rx_in_err, rx_in_data};
  assign rx_in_ready = f_ready & ~loop_en;
  wire tick = (cnt_r == '0);
  wire rise_out = tick & ~clk_r;
  wire fall_out = tick & clk_r;
  wire load = gig | ~rph_r;
  rgm_fifo #(.W(ENTRY_W), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(f_ivalid),
    .in_ready(f_ready),
    .in_data(f_idata),
    .out_valid(f_ovalid),
    .out_ready(rise_out & load),
    .out_data(f_odata)
  );

  // in-band status nibble on both halves of idle
  // built from live inputs at every idle byte
  // Speed field must name the clock rate really sent, link or not
  wire [3:0] st_nib = {full_duplex, eff_spd, link_up};
  wire [ENTRY_W-1:0] idle_w = {2'b00, st_nib, st_nib};
  // buffer entries carry the receive coding as given
  wire [ENTRY_W-1:0] src = f_ovalid ? f_odata : idle_w;
  wire [ENTRY_W-1:0] byte_w = load ? src : cur_r;

  // Link clock divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else begin
      cnt_r <= tick ? half - CNT_W'(1) : cnt_r - CNT_W'(1);
      clk_r <= clk_r ^ tick;
    end
  end

  // valid at rise, valid xor error at fall
  // control keeps both values at slow speeds
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '0;
      rph_r <= 1'b0;
      rctl_r <= 1'b0;
      rnib_r <= 4'h0;
    end else if (rise_out) begin
      cur_r <= byte_w;
      rph_r <= gig ? 1'b0 : ~rph_r;
      rctl_r <= byte_w[9];
      rnib_r <= load ? byte_w[3:0] : byte_w[7:4];
    end else if (fall_out) begin
      rctl_r <= cur_r[9] ^ cur_r[8];
      rnib_r <= gig ? cur_r[7:4] : rnib_r;
    end
  end

  // Egress clock delay line
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_out_r <= '0;
    end else begin
      sh_out_r <= {sh_out_r[5:0], clk_r};
    end
  end

  wire [7:0] out_taps = {sh_out_r, clk_r};
  // serial mode may stop the receive clock
  wire rxc_gate = (if_mode == MODE_SERIAL) & rxclk_off;
  assign lnk.rxc = out_taps[skew_out_r] & ~rxc_gate;
  assign lnk.rx_ctl = rctl_r;
  assign lnk.rxd = rnib_r;
endmodule : rgm_phy

// ==== design/rgm_mac.sv ====
// MAC end of the link: sends transmit nibbles, decodes receive ones.
// Assumes the device end drives the receive clock and in-band status.
`timescale 1ns/1ps
module rgm_mac
  import rgm_pkg::*;
#(
  parameter int HALF_G = HALF_1000,
  parameter int HALF_F = HALF_100,
  parameter int HALF_S = HALF_10
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  rgm_if.mac lnk,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic [7:0] tx_data,
  output logic rx_out_valid,
  output logic rx_out_dv,
  output logic rx_out_er,
  output logic [7:0] rx_out_data,
  output logic st_link_up,
  output logic [1:0] st_speed,
  output logic st_full_duplex
);
  logic [5:0] ls1_r;
  logic [5:0] ls2_r;
  logic rck_d_r;
  logic rctl_r;
  logic [3:0] rnib_r;
  logic [3:0] rlo_r;
  logic rph_r;
  logic [3:0] st_r;
  logic [CNT_W-1:0] cnt_r;
  logic clk_r;
  logic [ENTRY_W-1:0] cur_r;
  logic tph_r;
  logic tctl_r;
  logic [3:0] tnib_r;

  // Speed learned from in-band status
  assign st_link_up = st_r[ST_LINK_BIT];
  assign st_speed = st_r[ST_SPD_LSB+:2];
  assign st_full_duplex = st_r[ST_DPX_BIT];
  wire gig = (st_speed == SPD_1000) | (st_speed == 2'h3);
  wire [CNT_W-1:0] half = (st_speed == SPD_10) ? CNT_W'(HALF_S) :
    (st_speed == SPD_100) ? CNT_W'(HALF_F) : CNT_W'(HALF_G);

  // Receive pins through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls1_r <= '0;
      ls2_r <= '0;
      rck_d_r <= 1'b0;
    end else begin
      ls1_r <= {lnk.rxc, lnk.rx_ctl, lnk.rxd};
      ls2_r <= ls1_r;
      rck_d_r <= ls2_r[5];
    end
  end

  wire rise_in = ls2_r[5] & ~rck_d_r;
  wire fall_in = ~ls2_r[5] & rck_d_r;
  wire [3:0] r_nib = ls2_r[3:0];
  // second half is valid xor error
  wire r_er = rctl_r ^ ls2_r[4];
  wire r_act = rctl_r | r_er;
  wire r_done = fall_in & r_act & (gig | rph_r);
  // idle with matching nibbles holds status
  wire st_take = fall_in & ~r_act & (rnib_r == r_nib);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rctl_r <= 1'b0;
      rnib_r <= 4'h0;
      rlo_r <= 4'h0;
      rph_r <= 1'b0;
      st_r <= 4'h0;
    end else if (rise_in) begin
      rctl_r <= ls2_r[4];
      rnib_r <= r_nib;
    end else if (fall_in) begin
      rlo_r <= rph_r ? rlo_r : rnib_r;
      rph_r <= (r_act && !gig) ? ~rph_r : 1'b0;
      st_r <= st_take ? rnib_r : st_r;
    end
  end

  // received bytes with their valid and error flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_out_valid <= 1'b0;
      rx_out_dv <= 1'b0;
      rx_out_er <= 1'b0;
      rx_out_data <= 8'h00;
    end else begin
      rx_out_valid <= r_done;
      if (r_done) begin
        rx_out_dv <= rctl_r;
        rx_out_er <= r_er;
        rx_out_data <= gig ? {r_nib, rnib_r} : {rnib_r, rlo_r};
      end
    end
  end

  // transmit clock made here by a divider
  wire tick = (cnt_r == '0);
  wire rise_out = tick & ~clk_r;
  wire fall_out = tick & clk_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else begin
      cnt_r <= tick ? half - CNT_W'(1) : cnt_r - CNT_W'(1);
      clk_r <= clk_r ^ tick;
    end
  end

  // A byte is taken only at a period start; idle otherwise
  wire load = gig | ~tph_r;
  assign tx_ready = rise_out & load;
  wire [ENTRY_W-1:0] src = tx_valid ? {tx_en, tx_er, tx_data} : '0;
  wire [ENTRY_W-1:0] byte_w = load ? src : cur_r;

  // enable at rise, enable xor error at fall
  // control keeps both values at slow speeds
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '0;
      tph_r <= 1'b0;
      tctl_r <= 1'b0;
      tnib_r <= 4'h0;
    end else if (rise_out) begin
      cur_r <= byte_w;
      tph_r <= gig ? 1'b0 : ~tph_r;
      tctl_r <= byte_w[9];
      tnib_r <= load ? byte_w[3:0] : byte_w[7:4];
    end else if (fall_out) begin
      tctl_r <= cur_r[9] ^ cur_r[8];
      tnib_r <= gig ? cur_r[7:4] : tnib_r;
    end
  end

  assign lnk.txc = clk_r;
  assign lnk.tx_ctl = tctl_r;
  assign lnk.txd = tnib_r;
endmodule : rgm_mac

// ==== verif/rgm_link_monitor.sv ====
// Checker on the pins between the two link ends.
// Assumes divider settings 2/3/4 and egress skew of at most one tap.
`timescale 1ns/1ps
module rgm_link_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic txc,
  input wire logic tx_ctl,
  input wire logic [3:0] txd,
  input wire logic rxc,
  input wire logic rx_ctl,
  input wire logic [3:0] rxd
);
  logic [3:0] txd_rise_r;
  logic [3:0] rxd_rise_r;
  logic rxctl_rise_r;
  logic [3:0] tcnt_r;
  logic [3:0] rcnt_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Nibbles seen at the rising link edge, and half period lengths
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_rise_r <= 4'h0;
      rxd_rise_r <= 4'h0;
      rxctl_rise_r <= 1'b0;
      tcnt_r <= 4'h0;
      rcnt_r <= 4'h0;
    end else begin
      if ($rose(txc)) txd_rise_r <= txd;
      if ($rose(rxc)) rxd_rise_r <= rxd;
      if ($rose(rxc)) rxctl_rise_r <= rx_ctl;
      tcnt_r <= $changed(txc) ? 4'h0 : (tcnt_r == 4'hF ? tcnt_r : tcnt_r + 4'h1);
      rcnt_r <= $changed(rxc) ? 4'h0 : (rcnt_r == 4'hF ? rcnt_r : rcnt_r + 4'h1);
    end
  end
  a_txc_half_hold: assert property ($changed(txc) |=> $stable(txc))
    else $error("transmit clock half period too short");
  // Forcing the clock off lengthens a low phase or cuts a high one short
  a_rxc_low_hold: assert property ($fell(rxc) |=> !rxc)
    else $error("receive clock low phase too short");
  a_txc_running: assert property ($changed(txc) |-> ##[1:4] $changed(txc))
    else $error("transmit clock stalled");
  a_tx_on_edges: assert property (($changed(tx_ctl) || $changed(txd)) |-> $changed(txc))
    else $error("transmit lines moved between clock edges");
  a_tx_slow_repl: assert property ($fell(txc) && tcnt_r >= 4'h2 |-> txd == txd_rise_r)
    else $error("slow transmit nibble not repeated");
  a_rx_status_pair: assert property ($fell(rxc) && !rx_ctl && !rxctl_rise_r |-> rxd == rxd_rise_r)
    else $error("idle status nibbles differ");
  a_rx_slow_repl: assert property ($fell(rxc) && rcnt_r >= 4'h2 |-> rxd == rxd_rise_r)
    else $error("slow receive nibble not repeated");
  a_reset_launch: assert property ($rose(rst_n) |-> ##[1:3] txc)
    else $error("transmit clock not launched after reset");
endmodule : rgm_link_monitor

// ==== verif/testbench.sv ====
// Bench joining both ends; drives the MAC and device user sides.
// Assumes shortened dividers 2/3/4 so every speed grade runs quickly.
`timescale 1ns/1ps
module testbench;
  import rgm_pkg::*;
  logic sys_clk, rst_n, link_up, full_duplex, loop_en, ctl_lsb, ctl_msb, skew_wr, rxclk_off;
  logic [1:0] if_mode, speed, st_spd;
  logic [2:0] skew_in, skew_out;
  logic rx_in_valid, rx_in_ready, rx_in_dv, rx_in_err, tx_out_valid, capability_negotiation, pcs;
  logic [7:0] rx_in_data, tx_out_data, tx_data, rx_out_data;
  rgm_kind_t tx_out_kind;
  logic tx_valid, tx_ready, tx_en, tx_er, rx_out_valid, rx_out_dv, rx_out_er, st_link, st_fdx;
  logic [10:0] q_tx[$], q_rx[$], v;
  int err_total = 0, samples_checked = 0, n, i, k;
  // Transmit table {en,er,byte} and kinds; receive table {dv,er,byte}
  localparam logic [9:0] TTAB[6] = '{10'h2A5, 10'h33C, 10'h101, 10'h10F, 10'h11F, 10'h105};
  localparam rgm_kind_t TK[6] = '{K_DATA, K_ERR_PROP, K_LPI, K_EXT, K_EXT_ERR, K_RSVD};
  localparam logic [9:0] RTAB[6] = '{10'h25A, 10'h3C3, 10'h10E, 10'h1FF, 10'h101, 10'h11F};
  rgm_if lnk();
  rgm_phy #(.HALF_G(2), .HALF_F(3), .HALF_S(4)) i_rgm_phy (.sys_clk(sys_clk), .rst_n(rst_n),
    .lnk(lnk), .if_mode(if_mode), .link_up(link_up), .speed(speed), .full_duplex(full_duplex),
    .loop_en(loop_en), .ctl_speed_lsb(ctl_lsb), .ctl_speed_msb(ctl_msb), .skew_wr(skew_wr),
    .skew_in_val(skew_in), .skew_out_val(skew_out), .rxclk_off(rxclk_off),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_dv(rx_in_dv),
    .rx_in_err(rx_in_err), .rx_in_data(rx_in_data), .tx_out_valid(tx_out_valid),
    .tx_out_data(tx_out_data), .tx_out_kind(tx_out_kind), .capability_negotiation_gig_only(capability_negotiation), .pcs_en(pcs));
  rgm_mac #(.HALF_G(2), .HALF_F(3), .HALF_S(4)) i_rgm_mac (.sys_clk(sys_clk), .rst_n(rst_n),
    .lnk(lnk), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_en(tx_en), .tx_er(tx_er),
    .tx_data(tx_data), .rx_out_valid(rx_out_valid), .rx_out_dv(rx_out_dv),
    .rx_out_er(rx_out_er), .rx_out_data(rx_out_data), .st_link_up(st_link),
    .st_speed(st_spd), .st_full_duplex(st_fdx));
  rgm_link_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n), .txc(lnk.txc), .tx_ctl(lnk.tx_ctl),
    .txd(lnk.txd), .rxc(lnk.rxc), .rx_ctl(lnk.rx_ctl), .rxd(lnk.rxd));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Bytes delivered by either receiver, in arrival order
  always @(posedge sys_clk) begin
    if (tx_out_valid === 1'b1) q_tx.push_back({tx_out_kind, tx_out_data});
    if (rx_out_valid === 1'b1) q_rx.push_back({1'b0, rx_out_dv, rx_out_er, rx_out_data});
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for the next byte of one receiver; unknown if none
  task pop(input bit rx, output logic [10:0] r);
    int j;
    for (j = 0; j < 2000 && (rx ? q_rx.size() : q_tx.size()) == 0; j++) @(posedge sys_clk);
    r = 11'hXXX;
    if (rx && q_rx.size() > 0) r = q_rx.pop_front();
    if (!rx && q_tx.size() > 0) r = q_tx.pop_front();
    #1;
  endtask : pop
  // Request held until ready is seen at an edge
  task mac_send(input logic [9:0] e);
    int j;
    @(posedge sys_clk);
    #1 {tx_en, tx_er, tx_data} = e;
    tx_valid = 1'b1;
    for (j = 0; j < 300; j++) begin
      @(posedge sys_clk);
      if (tx_ready === 1'b1) break;
    end
    #1 tx_valid = 1'b0;
  endtask : mac_send
  task phy_push(input logic [9:0] e);
    int j;
    @(posedge sys_clk);
    #1 {rx_in_dv, rx_in_err, rx_in_data} = e;
    rx_in_valid = 1'b1;
    for (j = 0; j < 300; j++) begin
      @(posedge sys_clk);
      if (rx_in_ready === 1'b1) break;
    end
    #1 rx_in_valid = 1'b0;
  endtask : phy_push
  // Status reaches the MAC only through idle bytes, so poll with a bound
  task wait_st(input logic [3:0] e);
    int j;
    for (j = 0; j < 400 && {st_fdx, st_spd, st_link} !== e; j++) @(posedge sys_clk);
    #1 chk({7'h0, st_fdx, st_spd, st_link}, {7'h0, e});
  endtask : wait_st
  initial begin
    #300000;
    err_total++;
    end_of_test();
  end
  initial begin
    {rst_n, link_up, full_duplex, loop_en, ctl_lsb, ctl_msb, skew_wr, rxclk_off} = 8'h00;
    {if_mode, speed, skew_in, skew_out} = 10'h000;
    {rx_in_valid, rx_in_dv, rx_in_err, rx_in_data} = 11'h000;
    {tx_valid, tx_en, tx_er, tx_data} = 11'h000;
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    // Every speed grade, every transmit kind except K_IDLE and every receive code except CODE_EXT
    for (i = 0; i < 3; i++) begin
      speed = 2'(2 - i);
      full_duplex = ~i[0];
      link_up = 1'b1;
      wait_st({full_duplex, speed, 1'b1});
      for (k = 0; k < 6; k++) mac_send(TTAB[k]);
      for (k = 0; k < 6; k++) begin
        pop(1'b0, v);
        chk(v, {TK[k], TTAB[k][7:0]});
      end
      for (k = 0; k < 6; k++) phy_push(RTAB[k]);
      for (k = 0; k < 6; k++) begin
        pop(1'b1, v);
        chk(v, {1'b0, RTAB[k]});
      end
    end
    link_up = 1'b0;
    wait_st({full_duplex, speed, 1'b0});
    // Fill the receive buffer at the slowest rate, then drain it in order
    @(posedge sys_clk);
    #1 {rx_in_valid, rx_in_dv, rx_in_err, rx_in_data} = 11'h600;
    n = 0;
    for (k = 0; k < 60; k++) begin
      @(posedge sys_clk);
      if (rx_in_ready !== 1'b1) break;
      n++;
      #1 rx_in_data = n[7:0];
    end
    #1 rx_in_valid = 1'b0;
    chk(11'(n >= 32 && n <= 36), 11'h001);
    for (k = 0; k < n; k++) begin
      pop(1'b1, v);
      chk(v, {3'h2, k[7:0]});
    end
    // No link: loop speed and status follow the control bits
    ctl_lsb = 1'b1;
    wait_st({full_duplex, SPD_100, 1'b0});
    loop_en = 1'b1;
    mac_send(10'h2E1);
    pop(1'b0, v);
    chk(v, {K_DATA, 8'hE1});
    pop(1'b1, v);
    chk(v, 11'h2E1);
    loop_en = 1'b0;
    ctl_lsb = 1'b0;
    ctl_msb = 1'b1;
    wait_st({full_duplex, SPD_1000, 1'b0});
    speed = SPD_1000;
    link_up = 1'b1;
    wait_st({full_duplex, SPD_1000, 1'b1});
    // Test loop turns transmit bytes back to the MAC
    loop_en = 1'b1;
    #20 chk({10'h0, rx_in_ready}, 11'h000);
    mac_send(10'h277);
    pop(1'b0, v);
    chk(v, {K_DATA, 8'h77});
    pop(1'b1, v);
    chk(v, 11'h277);
    loop_en = 1'b0;
    if_mode = MODE_RTBI;
    #20 chk({9'h0, capability_negotiation, pcs}, 11'h003);
    if_mode = MODE_SERIAL;
    rxclk_off = 1'b1;
    #100 n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (lnk.rxc !== 1'b0) n++;
    end
    chk(11'(n), 11'h000);
    #1 if_mode = MODE_RGMII;
    rxclk_off = 1'b0;
    #20 chk({9'h0, capability_negotiation, pcs}, 11'h000);
    wait_st({full_duplex, SPD_1000, 1'b1});
    q_tx.delete();
    q_rx.delete();
    // Ingress skew below the half period keeps sampling intact
    skew_in = 3'h1;
    skew_out = 3'h1;
    skew_wr = 1'b1;
    #10 skew_wr = 1'b0;
    mac_send(10'h2C4);
    pop(1'b0, v);
    chk(v, {K_DATA, 8'hC4});
    phy_push(10'h2D3);
    pop(1'b1, v);
    chk(v, 11'h2D3);
    end_of_test();
  end
endmodule : testbench
